// file: rtl/boost_converter_switch_control.sv
// boost converter switch control with AHB-Lite register slave
`include "boost_map.svh"
module boost_converter_switch_control (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic osc_in,
    input wire logic overcurrent_in,
    input wire logic overvoltage_in,
    input wire logic vout_ok_in,
    input wire logic por_in,
    input wire logic boost_inductor_pin_in,
    input wire logic sleep_in,
    input wire logic low_power_in,
    input wire logic [7:0] ontime_req_in,
    output logic duty_sw_out,
    output logic bypass_sw_out,
    output logic enabled_out,
    output logic regulating_out,
    output logic [9:0] peak_limit_ma_out,
    output logic [3:0] vout_target_out,
    output logic [1:0] bypass_res_out,
    output logic [1:0] osc_trim_out
);
    localparam int OC = 0;
    localparam int OV = 1;
    localparam int VOK = 2;
    localparam int POR = 3;
    localparam int IND = 4;
    localparam int SLP = 5;
    localparam int LP = 6;

    boost_pkg::ctl_s q;
    boost_pkg::ctl_s n;
    logic tick;
    logic en;
    logic valid;
    logic [9:0] on_len;
    logic [7:0] status;

    function automatic logic [9:0] limit_ma(input logic ssel,
            input logic ilim, input logic lp);
        logic [1:0] k;
        k = {ssel, ilim};
        case (k)
            2'b10: limit_ma = lp ? 10'd75 : 10'd100;
            2'b11: limit_ma = lp ? 10'd100 : 10'd125;
            2'b00: limit_ma = lp ? 10'd125 : 10'd250;
            default: limit_ma = lp ? 10'd250 : 10'd500;
        endcase
    endfunction : limit_ma

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
            input logic [7:0] cfg, input logic [15:0] ctrl,
            input logic [7:0] st);
        case (a)
            `CFG_OFF: rd_mux = {24'h00_0000, cfg};
            `CTRL_OFF: rd_mux = {16'h0000, ctrl};
            `STAT_OFF: rd_mux = {24'h00_0000, st};
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction : rd_mux

    boost_clk_src u_clk (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .osc_in(osc_in),
        .sel_in(q.cfg[`CFG_CONVERTER_CLOCK_SELECT]),
        .inv_in(q.cfg[`CFG_CLKINV]),
        .div_in(q.cfg[`CFG_DIV_HI:`CFG_DIV_LO]),
        .tick_out(tick)
    );

    always_comb begin
        n = q;
        n.s1 = {low_power_in, sleep_in, boost_inductor_pin_in, por_in,
            vout_ok_in, overvoltage_in, overcurrent_in};
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 7; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.stab[i] = q.s3[i];
            end
        end
        // cell mode is taken only while power-on reset is active
        if (q.stab[POR]) begin
            n.one_cell = q.stab[IND];
        end
        en = q.one_cell && !q.stab[SLP];
        if (!en || q.stab[POR]) begin
            n.regulating = 1'b0;
        end else if (q.stab[VOK]) begin
            n.regulating = 1'b1;
        end
        if (tick) begin
            n.period = q.pcnt;
            n.pcnt = 10'h000;
        end else if (q.pcnt != 10'h3ff) begin
            n.pcnt = q.pcnt + 10'h001;
        end
        // startup runs half the measured period, regulation the request
        on_len = q.regulating ? {2'b00, ontime_req_in} : (q.period >> 1);
        if (tick) begin
            n.pend = 1'b1;
        end
        case (q.st)
            boost_pkg::SW_IDLE: begin
                n.pend = 1'b0;
                if (en) begin
                    n.st = boost_pkg::SW_WAIT;
                end
            end
            boost_pkg::SW_WAIT: begin
                if (tick || q.pend) begin
                    n.pend = 1'b0;
                    n.cnt = 10'h000;
                    if (q.stab[OC] || q.stab[OV]) begin
                        n.st = boost_pkg::SW_WAIT;
                    end else if (q.regulating && ontime_req_in <
                            q.ctrl[`CTRL_MINPW_HI:`CTRL_MINPW_LO]) begin
                        n.st = boost_pkg::SW_WAIT;
                    end else begin
                        n.st = boost_pkg::SW_CHARGE;
                    end
                end
            end
            boost_pkg::SW_CHARGE: begin
                n.cnt = q.cnt + 10'h001;
                if (q.stab[OC] || q.stab[OV] || n.cnt >= on_len) begin
                    n.st = boost_pkg::SW_DEAD1;
                    n.cnt = 10'h000;
                end
            end
            boost_pkg::SW_DEAD1: begin
                n.cnt = q.cnt + 10'h001;
                if (n.cnt >= 10'(`DEAD_CYC)) begin
                    n.st = boost_pkg::SW_DELIVER;
                    n.cnt = 10'h000;
                end
            end
            boost_pkg::SW_DELIVER: begin
                if (tick || q.stab[OV]) begin
                    n.st = boost_pkg::SW_DEAD2;
                end
            end
            boost_pkg::SW_DEAD2: begin
                n.cnt = q.cnt + 10'h001;
                if (n.cnt >= 10'(`DEAD_CYC)) begin
                    n.st = boost_pkg::SW_WAIT;
                    n.cnt = 10'h000;
                end
            end
            default: begin
                n.st = boost_pkg::SW_IDLE;
            end
        endcase
        if (!en) begin
            n.st = boost_pkg::SW_IDLE;
        end
        n.duty = (n.st == boost_pkg::SW_CHARGE);
        n.bypass = (n.st == boost_pkg::SW_DELIVER);
        n.enabled = en;
        if (q.stab[POR]) begin
            n.peak = `SOFT_LIMIT_MA;
        end else begin
            n.peak = limit_ma(q.ctrl[`CTRL_SWSIZE], q.ctrl[`CTRL_ILIM],
                q.stab[LP]);
        end
        // bus data phase of a write
        if (q.wr_pend) begin
            if (q.wr_addr == `CFG_OFF) begin
                n.cfg = hwdata_in[7:0];
            end else if (q.wr_addr == `CTRL_OFF) begin
                n.ctrl = hwdata_in[15:0];
            end
        end
        valid = hsel_in && hready_in && htrans_in[1];
        n.wr_pend = valid && hwrite_in;
        n.wr_addr = haddr_in[7:0];
        status = {q.st, q.regulating, q.one_cell, q.stab[POR],
            q.stab[OV], q.stab[OC]};
        if (valid && !hwrite_in) begin
            n.rdata = rd_mux(haddr_in[7:0], n.cfg, n.ctrl, status);
        end
        n.rdy = 1'b1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            q <= '0;
            q.cfg <= `CFG_RST;
            q.ctrl <= `CTRL_RST;
            q.rdy <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign hrdata_out = q.rdata;
    assign hreadyout_out = q.rdy;
    assign hresp_out = 1'b0;
    assign duty_sw_out = q.duty;
    assign bypass_sw_out = q.bypass;
    assign enabled_out = q.enabled;
    assign regulating_out = q.regulating;
    assign peak_limit_ma_out = q.peak;
    assign vout_target_out = q.ctrl[`CTRL_VOUT_HI:`CTRL_VOUT_LO];
    assign bypass_res_out = q.ctrl[`CTRL_BYP_HI:`CTRL_BYP_LO];
    assign osc_trim_out = q.cfg[`CFG_TRIM_HI:`CFG_TRIM_LO];

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    no_overlap_a: assert property (!(duty_sw_out && bypass_sw_out))
        else $error("both switches closed");
    dead_gap_a: assert property ($fell(bypass_sw_out) |-> !duty_sw_out ##1
        !duty_sw_out)
        else $error("no dead time before charge");
    charge_to_deliver_a: assert property ($fell(duty_sw_out) && enabled_out
        ##1 enabled_out |-> bypass_sw_out)
        else $error("deliver phase did not follow charge");
    soft_limit_a: assert property (q.stab[POR] |=>
        peak_limit_ma_out == 10'd125)
        else $error("soft start limit not applied");
    limit_decode_a: assert property (!q.stab[POR] && !q.stab[LP] &&
        q.ctrl[1:0] == 2'b10 |=> peak_limit_ma_out == 10'd500)
        else $error("peak limit decode wrong");
    ctrl_write_a: assert property (q.wr_pend && q.wr_addr == `CTRL_OFF
        |=> q.ctrl == $past(hwdata_in[15:0]))
        else $error("control write lost");
    oc_cut_a: assert property (duty_sw_out && q.stab[OC] |=>
        !duty_sw_out)
        else $error("overcurrent did not end charge");
    ov_stop_a: assert property (q.stab[OV] && q.st !=
        boost_pkg::SW_CHARGE |=> !duty_sw_out)
        else $error("switching not suppressed on overvoltage");
    skip_pulse_a: assert property (q.st == boost_pkg::SW_WAIT &&
        q.regulating && ontime_req_in < q.ctrl[9:2] |=> !duty_sw_out)
        else $error("short pulse not skipped");
    two_cell_off_a: assert property (!q.one_cell |=>
        !duty_sw_out && !bypass_sw_out && !enabled_out)
        else $error("converter active in two-cell mode");
endmodule : boost_converter_switch_control

// file: rtl/boost_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef BOOST_MAP_SVH
`define BOOST_MAP_SVH
`define CFG_OFF 8'h00
`define CTRL_OFF 8'h04
`define STAT_OFF 8'h08
`define CFG_CONVERTER_CLOCK_SELECT 0
`define CFG_TRIM_LO 1
`define CFG_TRIM_HI 2
`define CFG_CLKINV 3
`define CFG_DIV_LO 5
`define CFG_DIV_HI 6
`define CFG_RST 8'h00
`define CTRL_SWSIZE 0
`define CTRL_ILIM 1
`define CTRL_MINPW_LO 2
`define CTRL_MINPW_HI 9
`define CTRL_VOUT_LO 10
`define CTRL_VOUT_HI 13
`define CTRL_BYP_LO 14
`define CTRL_BYP_HI 15
`define CTRL_RST 16'h0403
`define SOFT_LIMIT_MA 10'd125
`define CLK_NS 5
`define DEAD_NS 5
`define DEAD_CYC ((`DEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define DIV_BASE 10'h0040
`endif

// file: rtl/boost_pkg.sv
// types of the boost converter switch control
package boost_pkg;
    typedef enum logic [2:0] {
        SW_IDLE, SW_WAIT, SW_CHARGE, SW_DEAD1, SW_DELIVER, SW_DEAD2
    } sw_state_e;
    typedef struct packed {
        sw_state_e st;
        logic [9:0] cnt;
        logic [9:0] pcnt;
        logic [9:0] period;
        logic pend;
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] stab;
        logic one_cell;
        logic regulating;
        logic [7:0] cfg;
        logic [15:0] ctrl;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic rdy;
        logic duty;
        logic bypass;
        logic enabled;
        logic [9:0] peak;
    } ctl_s;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic [9:0] cnt;
        logic tick;
    } clk_s;
endpackage : boost_pkg

// file: rtl/boost_clk_src.sv
// switching clock source: internal oscillator or divided system clock
`include "boost_map.svh"
module boost_clk_src (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic osc_in,
    input wire logic sel_in,
    input wire logic inv_in,
    input wire logic [1:0] div_in,
    output logic tick_out
);
    boost_pkg::clk_s q;
    boost_pkg::clk_s n;
    logic [9:0] lim;

    always_comb begin
        n = q;
        lim = (`DIV_BASE << div_in) - 10'h0001;
        n.s1 = osc_in;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.lvl = q.s3;
        end
        n.cnt = (q.cnt >= lim) ? 10'h0000 : q.cnt + 10'h0001;
        if (sel_in) begin
            // divided system clock, inverted moves the edge half a period
            n.tick = inv_in ? (q.cnt == (lim >> 1)) : (q.cnt == 10'h0000);
        end else begin
            n.tick = n.lvl && !q.lvl;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick_out = q.tick;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    div_tick_a: assert property (
        (sel_in && !inv_in && q.cnt == 10'h0000 && $stable(sel_in))
        |=> tick_out)
        else $error("divided clock tick missing");
endmodule : boost_clk_src

// file: test/tb_top.sv
// self-checking testbench of the boost converter switch control
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in, rstn_in, hsel_in, hwrite_in, hready_in, osc_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0] htrans_in, bypass_res_out, osc_trim_out;
    logic [2:0] hsize_in;
    logic hreadyout_out, hresp_out, overcurrent_in, overvoltage_in;
    logic vout_ok_in, por_in, boost_inductor_pin_in, sleep_in, low_power_in;
    logic [7:0] ontime_req_in;
    logic duty_sw_out, bypass_sw_out, enabled_out, regulating_out;
    logic [9:0] peak_limit_ma_out;
    logic [3:0] vout_target_out;
    logic osc_run;
    int error_cnt, n_tests, w, g;
    logic [31:0] rd;
    assign hready_in = hreadyout_out;
    boost_converter_switch_control dut (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hready_in),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .osc_in(osc_in),
        .overcurrent_in(overcurrent_in), .overvoltage_in(overvoltage_in),
        .vout_ok_in(vout_ok_in), .por_in(por_in),
        .boost_inductor_pin_in(boost_inductor_pin_in),
        .sleep_in(sleep_in), .low_power_in(low_power_in),
        .ontime_req_in(ontime_req_in), .duty_sw_out(duty_sw_out),
        .bypass_sw_out(bypass_sw_out), .enabled_out(enabled_out),
        .regulating_out(regulating_out),
        .peak_limit_ma_out(peak_limit_ma_out),
        .vout_target_out(vout_target_out),
        .bypass_res_out(bypass_res_out), .osc_trim_out(osc_trim_out));
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // oscillator stand-in: 80 cycle period, only while running
    initial begin
        int c;
        c = 0;
        forever begin
            @(posedge mclk_in);
            if (osc_run) begin
                c++;
                if (c == 40) begin
                    osc_in <= ~osc_in;
                    c = 0;
                end
            end
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    always @(posedge mclk_in) begin
        if (rstn_in && duty_sw_out === 1'b1 && bypass_sw_out === 1'b1) begin
            chk(1, 0);
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= wr;
        hsize_in <= 3'b010;
        htrans_in <= 2'b10;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hsel_in <= 1'b0;
        hwdata_in <= d;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
        chk(hresp_out, 0);
    endtask : bus
    // wait up to lim cycles for a pulse: g = gap, w = width
    task automatic pulse(input int lim);
        w = 0;
        g = 0;
        while (duty_sw_out !== 1'b1 && g < lim) begin
            @(posedge mclk_in);
            #1 g++;
        end
        while (duty_sw_out === 1'b1 && w < 2000) begin
            @(posedge mclk_in);
            #1 w++;
        end
    endtask : pulse
    task automatic t_regs;
        bus(0, 32'h0000_0004, 0);
        chk(rd, 32'h0000_0403);
        chk(vout_target_out, 4'h1);
        bus(1, 32'h0000_0000, 32'h0000_0093);
        bus(0, 32'h0000_0000, 0);
        chk(rd, 32'h0000_0093);
        chk(osc_trim_out, 2'h1);
        bus(1, 32'h0000_0000, 32'h0000_0000);
        bus(1, 32'h0000_0004, 32'h0000_fc10);
        bus(0, 32'h0000_000c, 0);
        chk(rd, 0);
        chk(vout_target_out, 4'hf);
        chk(bypass_res_out, 2'h3);
    endtask : t_regs
    task automatic t_peak;
        logic [9:0] tbl [8];
        tbl = '{10'd250, 10'd125, 10'd500, 10'd250,
                10'd100, 10'd75, 10'd125, 10'd100};
        por_in <= 1'b1;
        boost_inductor_pin_in <= 1'b1;
        bus(1, 32'h0000_0004, 32'h0000_0412);
        cyc(12);
        chk(peak_limit_ma_out, 10'd125);
        por_in <= 1'b0;
        cyc(12);
        chk(enabled_out, 1);
        for (int i = 0; i < 8; i++) begin
            bus(1, 32'h0000_0004, 32'h0000_0410 | (i >> 1));
            low_power_in <= i[0];
            cyc(12);
            chk(peak_limit_ma_out, tbl[{i[1], i[2], i[0]}]);
        end
        low_power_in <= 1'b0;
    endtask : t_peak
    task automatic t_start;
        osc_run <= 1'b1;
        pulse(400);
        pulse(200);
        pulse(200);
        chk(w >= 39 && w <= 41, 1);
        chk(duty_sw_out, 0);
        @(posedge mclk_in);
        #1 chk(bypass_sw_out, 1);
        pulse(200);
        chk(g > 0 && g < 90 && w > 0, 1);
        while (duty_sw_out !== 1'b1) @(posedge mclk_in);
        cyc(5);
        overcurrent_in <= 1'b1;
        #1 pulse(1);
        chk(w <= 7, 1);
        @(posedge mclk_in);
        #1 chk(bypass_sw_out, 1);
        pulse(200);
        chk(w, 0);
        overcurrent_in <= 1'b0;
    endtask : t_start
    task automatic t_reg;
        ontime_req_in <= 8'd20;
        vout_ok_in <= 1'b1;
        cyc(10);
        bus(0, 32'h0000_0008, 0);
        chk(rd[4], 1);
        pulse(200);
        pulse(200);
        chk(w, 20);
        ontime_req_in <= 8'd3;
        pulse(300);
        chk(w, 0);
        ontime_req_in <= 8'd20;
        overvoltage_in <= 1'b1;
        cyc(10);
        pulse(300);
        chk(w, 0);
        overvoltage_in <= 1'b0;
    endtask : t_reg
    task automatic t_div;
        osc_run <= 1'b0;
        ontime_req_in <= 8'd10;
        cyc(1);
        bus(1, 32'h0000_0000, 32'h0000_0001);
        pulse(300);
        pulse(200);
        rd = w;
        pulse(200);
        chk(rd + g, 64);
        chk(w, 10);
    endtask : t_div
    task automatic t_sleep;
        sleep_in <= 1'b1;
        cyc(10);
        chk(enabled_out, 0);
        pulse(200);
        chk(w, 0);
        chk(bypass_sw_out, 0);
    endtask : t_sleep
    task automatic wrap_up;
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        error_cnt = 0;
        n_tests = 0;
        osc_run = 1'b0;
        osc_in = 1'b0;
        rstn_in = 1'b0;
        {hsel_in, hwrite_in, overcurrent_in, overvoltage_in} = '0;
        {vout_ok_in, por_in, boost_inductor_pin_in, sleep_in} = '0;
        low_power_in = 1'b0;
        htrans_in = 2'b00;
        hsize_in = 3'b010;
        haddr_in = '0;
        hwdata_in = '0;
        ontime_req_in = 8'd0;
        cyc(10);
        rstn_in <= 1'b1;
        cyc(1);
        t_regs();
        t_peak();
        t_start();
        t_reg();
        t_div();
        t_sleep();
        wrap_up();
    end
endmodule : tb_top
